//--- spf_defs.svh
/*
 shared pin function select: constants for offsets, fields, reset values.
 assumes inclusion by bare name from the package and the design modules.
*/
`ifndef SPF_DEFS_SVH
`define SPF_DEFS_SVH

// register byte offsets
`define SPF_OFF_PORT6_DATA 8'h00
`define SPF_OFF_ANALOG_EN 8'h04
`define SPF_OFF_PORT7_DATA 8'h08
`define SPF_OFF_PORT7_DIR 8'h0C
`define SPF_OFF_PORT8_DATA 8'h10
`define SPF_OFF_PORT8_DIR 8'h14
`define SPF_OFF_PORT5_DATA 8'h18
`define SPF_OFF_PORT5_DIR 8'h1C
`define SPF_OFF_FUNC_EN 8'h20
`define SPF_OFF_PIN_LEVEL 8'h24

// pin counts
`define SPF_P6_W 6
`define SPF_P7_W 6
`define SPF_P8_W 3
`define SPF_P5_W 2

// reset values
`define SPF_P6_RST 6'h3F
`define SPF_AEN_RST 6'h3F
`define SPF_ZERO6 6'h00
`define SPF_ZERO3 3'h0
`define SPF_ZERO2 2'h0
`define SPF_FEN_RST 8'h00
`define SPF_ZERO32 32'h0000_0000

// function enable fields
`define SPF_FEN_TMR0 0
`define SPF_FEN_TMR1 1
`define SPF_FEN_TMR2 2
`define SPF_FEN_SCLK 3
`define SPF_FEN_SDO 4
`define SPF_FEN_XBUS 5
`define SPF_FEN_XIRQ 6
`define SPF_FEN_W 8

// port 7 bit positions
`define SPF_P7_SCLK 3
`define SPF_P7_SDI 4
`define SPF_P7_SDO 5
// port 5 bit positions (0 is read strobe pin, 1 is capture 3 / irq 3 pin)
`define SPF_P5_RD 0
`define SPF_P5_CAP3 1
// port 8 bit positions
`define SPF_P8_IRQ2 2

// axi responses
`define SPF_RESP_OKAY 2'h0
`define SPF_RESP_SLVERR 2'h2

`endif

//--- spf_pkg.sv
/*
 shared pin function select: package of types.
 assumes spf_defs.svh sits in the same folder.
*/
`include "spf_defs.svh"
package spf_pkg;
	typedef enum logic [1:0] {
		SPF_W_IDLE = 2'h0,
		SPF_W_RESP = 2'h1
	} spf_wstate_t;
	typedef enum logic [1:0] {
		SPF_R_IDLE = 2'h0,
		SPF_R_DATA = 2'h1
	} spf_rstate_t;
endpackage

//--- spf_sync.sv
/*
 spf_sync: two flip-flop synchroniser for a bus of pin levels.
 assumes the inputs are asynchronous to aclk.
*/
`timescale 1ns/1ps
`default_nettype none
module spf_sync #(
	parameter int W = 1
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} spf_sync_state_t;
	spf_sync_state_t s_q, s_d;

	always_comb begin
		s_d = s_q;
		s_d.meta = async_in;
		s_d.stable = s_q.meta;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign sync_out = s_q.stable;
endmodule
`default_nettype wire

//--- spf_pin_mux.sv
/*
 spf_pin_mux: pin sharing for ports 5 to 8 with an axi4-lite register slave.
 assumes the peripherals sit on aclk and board pins pass through spf_sync.
*/
// Summary of operation
// - analog-enable 0: plain data reads give live pin level, rmw reads the latch.
// - open-drain pins driven from data latch; 0 pulls low, 1 releases.
// - timer output pins are port pins unless the timer output is enabled.
// - serial clock pin is a port pin unless serial clock output enabled.
// - serial data-out pin is a port pin unless serial data output enabled.
// - always-available port pins keep port access; peripheral inputs sample in parallel.
// - irq lines 0 and 1 sampled whenever external interrupts enabled.
// - irq line 2 clamped low while the processor is stopped.
// - irq line 2 pin also feeds converter start trigger while it waits.
// - one pin is port, capture input 3 and irq line 3 concurrently.
// - one port pin outputs bus read strobe when external bus is used.
`timescale 1ns/1ps
`default_nettype none
`include "spf_defs.svh"
module spf_pin_mux
	import spf_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic rmw_read,
	input wire logic [5:0] port6_pin_in,
	output logic [5:0] port6_pin_oe,
	input wire logic [5:0] port7_pin_in,
	output logic [5:0] port7_pin_out,
	output logic [5:0] port7_pin_oe,
	input wire logic [2:0] port8_pin_in,
	output logic [2:0] port8_pin_out,
	output logic [2:0] port8_pin_oe,
	input wire logic [1:0] port5_pin_in,
	output logic [1:0] port5_pin_out,
	output logic [1:0] port5_pin_oe,
	input wire logic [2:0] timer_out,
	input wire logic serial_clock_out,
	output logic serial_clock_in,
	input wire logic serial_data_out,
	output logic serial_data_in,
	input wire logic bus_read_strobe,
	input wire logic cpu_stopped,
	input wire logic converter_waiting,
	output logic converter_start_trigger,
	output logic [3:0] ext_irq_line,
	output logic capture_input_3,
	output logic [5:0] analog_channel_active
);
	typedef struct packed {
		spf_wstate_t ws;
		spf_rstate_t rs;
		logic [7:0] waddr;
		logic aw_got;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic w_got;
		logic [1:0] bresp;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [5:0] p6_data;
		logic [5:0] analog_en;
		logic [5:0] p7_data;
		logic [5:0] p7_dir;
		logic [2:0] p8_data;
		logic [2:0] p8_dir;
		logic [1:0] p5_data;
		logic [1:0] p5_dir;
		logic [7:0] func_en;
		logic [5:0] p6_oe;
		logic [5:0] p7_out;
		logic [5:0] p7_oe;
		logic [2:0] p8_out;
		logic [2:0] p8_oe;
		logic [1:0] p5_out;
		logic [1:0] p5_oe;
		logic sclk_in;
		logic sdi;
		logic trig;
		logic [3:0] irq;
		logic cap3;
		logic [5:0] an_act;
	} spf_state_t;
	spf_state_t s_q, s_d;

	logic [5:0] p6_sync;
	logic [5:0] p7_sync;
	logic [2:0] p8_sync;
	logic [1:0] p5_sync;

	////////////////////////////////////////////////////////////////////////////
	spf_sync #(.W(`SPF_P6_W)) u_sync6 (.aclk(aclk), .aresetn(aresetn),
		.async_in(port6_pin_in), .sync_out(p6_sync));
	spf_sync #(.W(`SPF_P7_W)) u_sync7 (.aclk(aclk), .aresetn(aresetn),
		.async_in(port7_pin_in), .sync_out(p7_sync));
	spf_sync #(.W(`SPF_P8_W)) u_sync8 (.aclk(aclk), .aresetn(aresetn),
		.async_in(port8_pin_in), .sync_out(p8_sync));
	spf_sync #(.W(`SPF_P5_W)) u_sync5 (.aclk(aclk), .aresetn(aresetn),
		.async_in(port5_pin_in), .sync_out(p5_sync));

	////////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] merge8(input logic [7:0] old, input logic [31:0] d,
		input logic [3:0] st);
		merge8 = st[0] ? d[7:0] : old;
	endfunction

	logic [31:0] rd_val;
	logic rd_hit;
	logic [5:0] p6_rd;

	always_comb begin
		// rmw reads the latch so a bit-set does not copy a pulled-low pin back
		p6_rd = s_q.p6_data;
		for (int i = 0; i < `SPF_P6_W; i++) begin
			if (!s_q.analog_en[i] && !rmw_read) begin
				p6_rd[i] = p6_sync[i];
			end
		end
		rd_hit = 1'b1;
		rd_val = `SPF_ZERO32;
		unique case (s_axi_araddr)
			`SPF_OFF_PORT6_DATA: rd_val = {26'h0, p6_rd};
			`SPF_OFF_ANALOG_EN: rd_val = {26'h0, s_q.analog_en};
			`SPF_OFF_PORT7_DATA: rd_val = {26'h0, s_q.p7_data};
			`SPF_OFF_PORT7_DIR: rd_val = {26'h0, s_q.p7_dir};
			`SPF_OFF_PORT8_DATA: rd_val = {29'h0, s_q.p8_data};
			`SPF_OFF_PORT8_DIR: rd_val = {29'h0, s_q.p8_dir};
			`SPF_OFF_PORT5_DATA: rd_val = {30'h0, s_q.p5_data};
			`SPF_OFF_PORT5_DIR: rd_val = {30'h0, s_q.p5_dir};
			`SPF_OFF_FUNC_EN: rd_val = {24'h0, s_q.func_en};
			`SPF_OFF_PIN_LEVEL: rd_val = {15'h0, p5_sync, p8_sync, p7_sync, p6_sync};
			default: rd_hit = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		s_d = s_q;
		// write channel: address and data taken in either order
		if (s_q.ws == SPF_W_IDLE) begin
			if (s_axi_awvalid && !s_q.aw_got) begin
				s_d.aw_got = 1'b1;
				s_d.waddr = s_axi_awaddr;
			end
			if (s_axi_wvalid && !s_q.w_got) begin
				s_d.w_got = 1'b1;
				s_d.wdata = s_axi_wdata;
				s_d.wstrb = s_axi_wstrb;
			end
			if (s_q.aw_got && s_q.w_got) begin
				s_d.aw_got = 1'b0;
				s_d.w_got = 1'b0;
				s_d.ws = SPF_W_RESP;
				s_d.bresp = `SPF_RESP_OKAY;
				unique case (s_q.waddr)
					`SPF_OFF_PORT6_DATA: s_d.p6_data = 6'(merge8({2'h0, s_q.p6_data},
						s_q.wdata, s_q.wstrb));
					`SPF_OFF_ANALOG_EN: s_d.analog_en = 6'(merge8({2'h0, s_q.analog_en},
						s_q.wdata, s_q.wstrb));
					`SPF_OFF_PORT7_DATA: s_d.p7_data = 6'(merge8({2'h0, s_q.p7_data},
						s_q.wdata, s_q.wstrb));
					`SPF_OFF_PORT7_DIR: s_d.p7_dir = 6'(merge8({2'h0, s_q.p7_dir},
						s_q.wdata, s_q.wstrb));
					`SPF_OFF_PORT8_DATA: s_d.p8_data = 3'(merge8({5'h0, s_q.p8_data},
						s_q.wdata, s_q.wstrb));
					`SPF_OFF_PORT8_DIR: s_d.p8_dir = 3'(merge8({5'h0, s_q.p8_dir},
						s_q.wdata, s_q.wstrb));
					`SPF_OFF_PORT5_DATA: s_d.p5_data = 2'(merge8({6'h0, s_q.p5_data},
						s_q.wdata, s_q.wstrb));
					`SPF_OFF_PORT5_DIR: s_d.p5_dir = 2'(merge8({6'h0, s_q.p5_dir},
						s_q.wdata, s_q.wstrb));
					`SPF_OFF_FUNC_EN: s_d.func_en = merge8(s_q.func_en, s_q.wdata,
						s_q.wstrb);
					`SPF_OFF_PIN_LEVEL: s_d.bresp = `SPF_RESP_OKAY;
					default: s_d.bresp = `SPF_RESP_SLVERR;
				endcase
			end
		end else if (s_axi_bready) begin
			s_d.ws = SPF_W_IDLE;
		end
		// read channel: one cycle from address to data
		if (s_q.rs == SPF_R_IDLE) begin
			if (s_axi_arvalid) begin
				s_d.rs = SPF_R_DATA;
				s_d.rdata = rd_val;
				s_d.rresp = rd_hit ? `SPF_RESP_OKAY : `SPF_RESP_SLVERR;
			end
		end else if (s_axi_rready) begin
			s_d.rs = SPF_R_IDLE;
		end

		// open drain: only pull low, never drive high
		s_d.p6_oe = ~s_q.p6_data;
		s_d.an_act = s_q.analog_en & s_q.p6_data;

		// port 7: timers, serial clock and data out
		s_d.p7_out = s_q.p7_data;
		s_d.p7_oe = s_q.p7_dir;
		for (int t = 0; t < 3; t++) begin
			if (s_q.func_en[t]) begin
				s_d.p7_out[t] = timer_out[t];
				s_d.p7_oe[t] = 1'b1;
			end
		end
		if (s_q.func_en[`SPF_FEN_SCLK]) begin
			s_d.p7_out[`SPF_P7_SCLK] = serial_clock_out;
			s_d.p7_oe[`SPF_P7_SCLK] = 1'b1;
		end
		if (s_q.func_en[`SPF_FEN_SDO]) begin
			s_d.p7_out[`SPF_P7_SDO] = serial_data_out;
			s_d.p7_oe[`SPF_P7_SDO] = 1'b1;
		end
		// clock input always sampled so an external clock works when not driving
		s_d.sclk_in = p7_sync[`SPF_P7_SCLK];
		s_d.sdi = p7_sync[`SPF_P7_SDI];

		// port 8: always ports, irq sampling in parallel
		s_d.p8_out = s_q.p8_data;
		s_d.p8_oe = s_q.p8_dir;
		s_d.irq[0] = s_q.func_en[`SPF_FEN_XIRQ] & p8_sync[0];
		s_d.irq[1] = s_q.func_en[`SPF_FEN_XIRQ] & p8_sync[1];
		s_d.irq[2] = s_q.func_en[`SPF_FEN_XIRQ] & p8_sync[`SPF_P8_IRQ2] & !cpu_stopped;
		s_d.trig = converter_waiting & p8_sync[`SPF_P8_IRQ2];

		// port 5: read strobe and capture 3 / irq 3
		s_d.p5_out = s_q.p5_data;
		s_d.p5_oe = s_q.p5_dir;
		if (s_q.func_en[`SPF_FEN_XBUS]) begin
			s_d.p5_out[`SPF_P5_RD] = bus_read_strobe;
			s_d.p5_oe[`SPF_P5_RD] = 1'b1;
		end
		s_d.cap3 = p5_sync[`SPF_P5_CAP3];
		s_d.irq[3] = s_q.func_en[`SPF_FEN_XIRQ] & p5_sync[`SPF_P5_CAP3];
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= '0;
			s_q.ws <= SPF_W_IDLE;
			s_q.rs <= SPF_R_IDLE;
			s_q.p6_data <= `SPF_P6_RST;
			s_q.analog_en <= `SPF_AEN_RST;
			s_q.func_en <= `SPF_FEN_RST;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	assign s_axi_awready = (s_q.ws == SPF_W_IDLE) & !s_q.aw_got;
	assign s_axi_wready = (s_q.ws == SPF_W_IDLE) & !s_q.w_got;
	assign s_axi_bvalid = (s_q.ws == SPF_W_RESP);
	assign s_axi_bresp = s_q.bresp;
	assign s_axi_arready = (s_q.rs == SPF_R_IDLE);
	assign s_axi_rvalid = (s_q.rs == SPF_R_DATA);
	assign s_axi_rdata = s_q.rdata;
	assign s_axi_rresp = s_q.rresp;
	assign port6_pin_oe = s_q.p6_oe;
	assign port7_pin_out = s_q.p7_out;
	assign port7_pin_oe = s_q.p7_oe;
	assign port8_pin_out = s_q.p8_out;
	assign port8_pin_oe = s_q.p8_oe;
	assign port5_pin_out = s_q.p5_out;
	assign port5_pin_oe = s_q.p5_oe;
	assign serial_clock_in = s_q.sclk_in;
	assign serial_data_in = s_q.sdi;
	assign converter_start_trigger = s_q.trig;
	assign ext_irq_line = s_q.irq;
	assign capture_input_3 = s_q.cap3;
	assign analog_channel_active = s_q.an_act;

	////////////////////////////////////////////////////////////////////////////
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	od_pull_low_a: assert property (##1 port6_pin_oe == ~$past(s_q.p6_data))
		else $error("open drain enable does not follow data latch");
	tmr_out_sel_a: assert property (s_q.func_en[0] |=> port7_pin_oe[0]
		&& port7_pin_out[0] == $past(timer_out[0]))
		else $error("timer 0 output not on pin");
	tmr_port_sel_a: assert property (!s_q.func_en[1] |=> port7_pin_oe[1] == $past(s_q.p7_dir[1])
		&& port7_pin_out[1] == $past(s_q.p7_data[1]))
		else $error("timer 1 pin not a port when disabled");
	sclk_sel_a: assert property (s_q.func_en[3] |=> port7_pin_out[3] == $past(serial_clock_out))
		else $error("serial clock not on pin");
	sdo_sel_a: assert property (s_q.func_en[4] |=> port7_pin_oe[5]
		&& port7_pin_out[5] == $past(serial_data_out))
		else $error("serial data out not on pin");
	irq2_clamp_a: assert property (cpu_stopped |=> !ext_irq_line[2])
		else $error("irq line 2 not clamped while stopped");
	irq_enable_a: assert property (!s_q.func_en[6] |=> ext_irq_line == 4'h0)
		else $error("irq passed while disabled");
	trig_gate_a: assert property (!converter_waiting |=> !converter_start_trigger)
		else $error("trigger passed while converter not waiting");
	rd_strobe_a: assert property (s_q.func_en[5] |=> port5_pin_oe[0]
		&& port5_pin_out[0] == $past(bus_read_strobe))
		else $error("read strobe not on pin");
	cap3_path_a: assert property (##3 capture_input_3 == $past(port5_pin_in[1], 3))
		else $error("capture 3 path latency wrong");
	rst_port_a: assert property ($rose(aresetn) |-> s_q.func_en == `SPF_FEN_RST)
		else $error("alternate function enabled after reset");
	live_read_a: assert property (s_axi_arvalid && s_axi_arready
		&& s_axi_araddr == `SPF_OFF_PORT6_DATA && !rmw_read && s_q.analog_en == `SPF_ZERO6
		|=> s_axi_rdata[5:0] == $past(p6_sync))
		else $error("port 6 read not live pin level");

	wr_done_c: cover property (s_axi_bvalid && s_axi_bready);
	rd_done_c: cover property (s_axi_rvalid && s_axi_rready);
	irq0_c: cover property (ext_irq_line[0]);
	trig_c: cover property (converter_start_trigger);
endmodule
`default_nettype wire

//--- spf_board.sv
/*
 spf_board: board circuitry around the shared pins.
 assumes the bench sets the external levels just after rising edges of aclk.
*/
`timescale 1ns/1ps
`default_nettype none
module spf_board (
	input wire logic [5:0] p6_oe,
	input wire logic [5:0] p7_out,
	input wire logic [5:0] p7_oe,
	input wire logic [2:0] p8_out,
	input wire logic [2:0] p8_oe,
	input wire logic [1:0] p5_out,
	input wire logic [1:0] p5_oe,
	input wire logic [5:0] ext6,
	input wire logic [5:0] ext7,
	input wire logic [2:0] ext8,
	input wire logic [1:0] ext5,
	output logic [5:0] p6_pin,
	output logic [5:0] p7_pin,
	output logic [2:0] p8_pin,
	output logic [1:0] p5_pin
);
	////////////////////////////////////////////////////////////////////////////////
	// pull-up on open-drain pins: device pull-down or an external part may sink it
	assign p6_pin = ~p6_oe & ext6;
	// push-pull pins: an enabled driver wins, else the board level
	assign p7_pin = (p7_oe & p7_out) | (~p7_oe & ext7);
	assign p8_pin = (p8_oe & p8_out) | (~p8_oe & ext8);
	assign p5_pin = (p5_oe & p5_out) | (~p5_oe & ext5);
endmodule
`default_nettype wire

//--- tb_shared_pin_function_select.sv
/*
 tb_shared_pin_function_select: self-checking bench for spf_pin_mux.
 assumes spf_pkg and spf_board are compiled first; one 250 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_shared_pin_function_select;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic rmw = 1'b0, sclk_o = 1'b0, sdo = 1'b0, rds = 1'b0, stopped = 1'b0, waiting = 1'b0;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0] wstrb = 4'h0;
	logic [2:0] tmr = 3'h0, ext8 = 3'h0;
	logic [5:0] ext6 = 6'h3F, ext7 = 6'h00;
	logic [1:0] ext5 = 2'h0;
	// board keeps standby released from power-up, through every reset
	logic hardware_standby_low = 1'b1;
	wire logic awready, wready, bvalid, arready, rvalid, sclk_i, sdi, trig, cap3;
	wire logic [1:0] bresp, rresp, p5_in, p5_out, p5_oe;
	wire logic [31:0] rdata;
	wire logic [3:0] irq;
	wire logic [5:0] an_act, p6_in, p6_oe, p7_in, p7_out, p7_oe;
	wire logic [2:0] p8_in, p8_out, p8_oe;
	int n_mismatch = 0;
	int tests_run = 0;

	spf_pin_mux i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .rmw_read(rmw), .port6_pin_in(p6_in), .port6_pin_oe(p6_oe),
		.port7_pin_in(p7_in), .port7_pin_out(p7_out), .port7_pin_oe(p7_oe),
		.port8_pin_in(p8_in), .port8_pin_out(p8_out), .port8_pin_oe(p8_oe),
		.port5_pin_in(p5_in), .port5_pin_out(p5_out), .port5_pin_oe(p5_oe),
		.timer_out(tmr), .serial_clock_out(sclk_o), .serial_clock_in(sclk_i),
		.serial_data_out(sdo), .serial_data_in(sdi), .bus_read_strobe(rds),
		.cpu_stopped(stopped), .converter_waiting(waiting), .converter_start_trigger(trig),
		.ext_irq_line(irq), .capture_input_3(cap3), .analog_channel_active(an_act));

	spf_board i_board (.p6_oe(p6_oe), .p7_out(p7_out), .p7_oe(p7_oe), .p8_out(p8_out),
		.p8_oe(p8_oe), .p5_out(p5_out), .p5_oe(p5_oe), .ext6(ext6), .ext7(ext7),
		.ext8(ext8), .ext5(ext5), .p6_pin(p6_in), .p7_pin(p7_in), .p8_pin(p8_in),
		.p5_pin(p5_in));

	always #2 aclk = ~aclk;

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// write: both channels offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		// no cycle count assumed: a hang is left to the watchdog
		do begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk("bresp", bresp, er);
	endtask

	// read: rmw level held through the address handshake
	task automatic rd(input logic [7:0] a, input logic m, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		rmw <= m;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rready <= 1'b0;
		rmw <= 1'b0;
		d = rdata;
		r = rresp;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		logic [31:0] d;
		logic [1:0] r;
		chk("oe", {p5_oe, p8_oe, p7_oe, p6_oe}, 32'h0);
		chk("out", {p5_out, p8_out, p7_out}, 32'h0);
		chk("standby", hardware_standby_low, 32'h1);
		for (int i = 0; i < 9; i++) begin
			rd(8'(i * 4), 1'b0, d, r);
			chk("reset reg", d, (i < 2) ? 32'h3F : 32'h0);
		end
	endtask

	task automatic t_open_drain();
		logic [31:0] d;
		logic [1:0] r;
		wr(8'h04, 32'h0, 2'h0);
		wr(8'h00, 32'h05, 2'h0);
		ext6 <= 6'h3B;
		repeat (4) @(posedge aclk);
		chk("od oe", p6_oe, 32'h3A);
		rd(8'h00, 1'b0, d, r);
		chk("live", d, 32'h01);
		rd(8'h00, 1'b1, d, r);
		chk("rmw", d, 32'h05);
		// analog use: enable bits and data bits both set to 1
		wr(8'h04, 32'h3F, 2'h0);
		wr(8'h00, 32'h3F, 2'h0);
		repeat (2) @(posedge aclk);
		rd(8'h00, 1'b0, d, r);
		chk("latch", d, 32'h3F);
		chk("released", p6_oe, 32'h0);
		chk("analog", an_act, 32'h3F);
		ext6 <= 6'h3F;
	endtask

	task automatic t_func();
		wr(8'h0C, 32'h3F, 2'h0);
		wr(8'h1C, 32'h3, 2'h0);
		tmr <= 3'h5;
		sclk_o <= 1'b1;
		sdo <= 1'b1;
		rds <= 1'b1;
		wr(8'h20, 32'h3F, 2'h0);
		repeat (3) @(posedge aclk);
		chk("timer", p7_out[2:0], 32'h5);
		chk("sclk", p7_out[3], 32'h1);
		chk("sdo", p7_out[5], 32'h1);
		chk("strobe", p5_out[0], 32'h1);
		tmr <= 3'h0;
		sclk_o <= 1'b0;
		sdo <= 1'b0;
		rds <= 1'b0;
		wr(8'h20, 32'h0, 2'h0);
		wr(8'h08, 32'h2F, 2'h0);
		wr(8'h18, 32'h1, 2'h0);
		repeat (3) @(posedge aclk);
		chk("port mode", {p5_out[0], p7_out}, 32'h6F);
	endtask

	task automatic t_inputs();
		logic [31:0] d;
		logic [1:0] r;
		// every output on the input pins switched off first
		wr(8'h0C, 32'h0, 2'h0);
		wr(8'h1C, 32'h0, 2'h0);
		wr(8'h20, 32'h40, 2'h0);
		ext8 <= 3'h3;
		ext5 <= 2'h2;
		ext7 <= 6'h18;
		repeat (4) @(posedge aclk);
		chk("irq", irq, 32'hB);
		chk("cap3", cap3, 32'h1);
		chk("sdi", sdi, 32'h1);
		chk("sclk in", sclk_i, 32'h1);
		rd(8'h24, 1'b0, d, r);
		chk("levels", d, 32'h1363F);
		wr(8'h24, 32'h0, 2'h0);
		rd(8'h24, 1'b0, d, r);
		chk("levels ro", d, 32'h1363F);
		wr(8'h10, 32'h5, 2'h0);
		rd(8'h10, 1'b0, d, r);
		chk("p8 data", d, 32'h5);
		chk("p8 pins", {p8_oe, p8_out}, 32'h05);
	endtask

	task automatic t_stop();
		ext8 <= 3'h7;
		waiting <= 1'b1;
		repeat (4) @(posedge aclk);
		chk("irq run", irq[2:0], 32'h7);
		chk("trigger", trig, 32'h1);
		stopped <= 1'b1;
		waiting <= 1'b0;
		repeat (3) @(posedge aclk);
		chk("irq stop", irq[2:0], 32'h3);
		chk("trig idle", trig, 32'h0);
	endtask

	task automatic t_unmapped();
		logic [31:0] d;
		logic [1:0] r;
		wr(8'h3C, 32'hFF, 2'h2);
		rd(8'h3C, 1'b0, d, r);
		chk("rresp", r, 32'h2);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic finish_test();
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// run needs well under 2000 cycles
	initial begin
		repeat (5000) @(posedge aclk);
		n_mismatch++;
		finish_test();
	end

	initial begin
		// reset held longer than five machine cycles
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_open_drain();
		t_func();
		t_inputs();
		t_stop();
		t_unmapped();
		finish_test();
	end
endmodule
`default_nettype wire
